// [lbce_regs.svh]
`ifndef LBCE_REGS_SVH
`define LBCE_REGS_SVH

// Instruction codes; the edge and latch codes are the documented function
// codes, the remaining ones are free encodings of this executor.
`define LBCE_OP_SCAN_END 7'h01
`define LBCE_OP_IL_START 7'h02
`define LBCE_OP_IL_CLEAR 7'h03
`define LBCE_OP_LATCH 7'h0B
`define LBCE_OP_RISE 7'h0D
`define LBCE_OP_FALL 7'h0E
`define LBCE_OP_LOAD 7'h60
`define LBCE_OP_LOAD_NOT 7'h61
`define LBCE_OP_AND 7'h62
`define LBCE_OP_AND_NOT 7'h63
`define LBCE_OP_OR 7'h64
`define LBCE_OP_OR_NOT 7'h65
`define LBCE_OP_AND_BLK 7'h66
`define LBCE_OP_OR_BLK 7'h67
`define LBCE_OP_OUT 7'h68
`define LBCE_OP_OUT_NOT 7'h69
`define LBCE_OP_FLAGS_LD 7'h6A

// Bit memory layout: addresses at and above the base are retentive.
`define LBCE_RET_BASE 8'hC0
`define LBCE_NORM_BITS 192
`define LBCE_RET_BITS 64
`define LBCE_RET_IDX_W 6
`define LBCE_EDGE_SLOTS 16
`define LBCE_FLAG_BITS 4

`endif

// [lbce_pkg.sv]
package lbce_pkg;

  // One program step as handed over by the scan sequencer.
  typedef struct packed {
    logic [6:0] code;
    logic [7:0] addr;
    logic [3:0] slot;
  } lbce_instr_t;

endpackage

// [lbce_executor.sv]
// Contract
// R1: Block combine merges two conditions, AND/OR.
// R2: Output write copies condition to bit.
// R3: Inverted output writes inverse of condition.
// R4: Each edge instance stores its previous condition.
// R5: Rising pulse sets bit on OFF-to-ON.
// R6: Rising pulse clears bit when previous ON.
// R7: Falling pulse sets bit on ON-to-OFF.
// R8: Falling pulse clears bit when previous OFF.
// R9: Latch sets on set input, holds set.
// R10: Latch clears on reset input, holds clear.
// R11: Latch keeps state inside inactive interlock.
// R12: Holding/auxiliary latched bits survive power loss.
// R13: Latch leaves arithmetic flags unchanged.
// R14: Inactive interlock forces output targets OFF.
// R15: Inactive interlock freezes edge previous conditions.
// R16: Set and reset together: reset wins.
// R17: One instruction per cycle, results seen immediately.
`include "lbce_regs.svh"

module lbce_executor
  import lbce_pkg::*;
#(
  parameter int STK_DEPTH = 8
)
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic INSTR_VALID,
  input wire lbce_instr_t INSTR,
  input wire logic [7:0] RD_ADDR,
  output logic RD_DATA,
  output logic COND,
  output logic IL_ACTIVE,
  output logic [`LBCE_FLAG_BITS-1:0] FLAGS,
  output logic DONE
);

  // Reads one bit of the split memory; the top quarter is retentive.
  function automatic logic rd_bit(input logic [7:0] a,
                                  input logic [`LBCE_NORM_BITS-1:0] n,
                                  input logic [`LBCE_RET_BITS-1:0] r);
    logic v;
    v = 1'b0;
    if (a >= `LBCE_RET_BASE)
      v = r[a[`LBCE_RET_IDX_W-1:0]];
    else
      v = n[a];
    return v;
  endfunction

  logic cond_r, cond_nxt;
  logic [STK_DEPTH-1:0] stk_r, stk_nxt;
  logic il_r, il_nxt;
  logic [`LBCE_FLAG_BITS-1:0] flags_r, flags_nxt;
  logic [`LBCE_NORM_BITS-1:0] bits_r, bits_nxt;
  logic [`LBCE_RET_BITS-1:0] ret_r, ret_nxt;
  logic [`LBCE_EDGE_SLOTS-1:0] prev_r, prev_nxt;
  logic rd_r, rd_nxt;
  logic done_r, done_nxt;
  logic opnd;
  logic wr_en;
  logic wr_val;
  logic prev_c;

  // Executes one instruction per clock; memory is updated at the edge so
  // the next instruction of the scan already sees the new value.
  always_comb
  begin
    cond_nxt = cond_r;
    stk_nxt = stk_r;
    il_nxt = il_r;
    flags_nxt = flags_r;
    bits_nxt = bits_r;
    ret_nxt = ret_r;
    prev_nxt = prev_r;
    wr_en = 1'b0;
    wr_val = 1'b0;
    opnd = rd_bit(INSTR.addr, bits_r, ret_r);
    prev_c = prev_r[INSTR.slot];
    done_nxt = INSTR_VALID; // R17
    if (INSTR_VALID)
    begin
      case (INSTR.code)
        `LBCE_OP_LOAD, `LBCE_OP_LOAD_NOT:
        begin
          // The old condition is pushed as the next one to be used.
          stk_nxt = {stk_r[STK_DEPTH-2:0], cond_r};
          cond_nxt = (INSTR.code == `LBCE_OP_LOAD) ? opnd : ~opnd;
        end
        `LBCE_OP_AND:
          cond_nxt = cond_r & opnd;
        `LBCE_OP_AND_NOT:
          cond_nxt = cond_r & ~opnd;
        `LBCE_OP_OR:
          cond_nxt = cond_r | opnd;
        `LBCE_OP_OR_NOT:
          cond_nxt = cond_r | ~opnd;
        `LBCE_OP_AND_BLK:
        begin
          cond_nxt = cond_r & stk_r[0]; // R1
          stk_nxt = {1'b0, stk_r[STK_DEPTH-1:1]};
        end
        `LBCE_OP_OR_BLK:
        begin
          cond_nxt = cond_r | stk_r[0]; // R1
          stk_nxt = {1'b0, stk_r[STK_DEPTH-1:1]};
        end
        `LBCE_OP_OUT:
        begin
          wr_en = 1'b1;
          wr_val = il_r ? 1'b0 : cond_r; // R2 R14
        end
        `LBCE_OP_OUT_NOT:
        begin
          wr_en = 1'b1;
          wr_val = il_r ? 1'b0 : ~cond_r; // R3 R14
        end
        `LBCE_OP_RISE:
        begin
          // Not executed at all while the interlock holds.
          if (!il_r) // R15
          begin
            wr_en = 1'b1;
            wr_val = ~prev_c & cond_r; // R5 R6
            prev_nxt[INSTR.slot] = cond_r; // R4
          end
        end
        `LBCE_OP_FALL:
        begin
          if (!il_r) // R15
          begin
            wr_en = 1'b1;
            wr_val = prev_c & ~cond_r; // R7 R8
            prev_nxt[INSTR.slot] = cond_r; // R4
          end
        end
        `LBCE_OP_LATCH:
        begin
          // Set comes from the stacked condition, reset from the current.
          stk_nxt = {1'b0, stk_r[STK_DEPTH-1:1]};
          if (!il_r) // R11
          begin
            wr_en = 1'b1;
            if (cond_r)
              wr_val = 1'b0; // R10 R16
            else if (stk_r[0])
              wr_val = 1'b1; // R9
            else
              wr_val = opnd;
          end
        end
        `LBCE_OP_IL_START:
          il_nxt = il_r | ~cond_r;
        `LBCE_OP_IL_CLEAR:
          il_nxt = 1'b0;
        `LBCE_OP_FLAGS_LD:
          flags_nxt = INSTR.addr[`LBCE_FLAG_BITS-1:0];
        `LBCE_OP_SCAN_END:
        begin
          stk_nxt = '0;
          il_nxt = 1'b0;
        end
        default:
          done_nxt = 1'b1;
      endcase
    end
    if (wr_en)
    begin
      if (INSTR.addr >= `LBCE_RET_BASE)
        ret_nxt[INSTR.addr[`LBCE_RET_IDX_W-1:0]] = wr_val; // R12
      else
        bits_nxt[INSTR.addr] = wr_val;
    end
    rd_nxt = rd_bit(RD_ADDR, bits_nxt, ret_nxt);
  end

  // Working state; cleared at power-up.
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cond_r <= 1'b0;
      stk_r <= '0;
      il_r <= 1'b0;
      flags_r <= '0;
      bits_r <= '0;
      prev_r <= '0;
      rd_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cond_r <= cond_nxt;
      stk_r <= stk_nxt;
      il_r <= il_nxt;
      flags_r <= flags_nxt; // R13
      bits_r <= bits_nxt;
      prev_r <= prev_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
    end
  end

  // Retentive area has no reset on purpose: it models backed-up memory,
  // so its content after first power-on is undefined until written.
  always_ff @(posedge CLOCK)
  begin
    ret_r <= ret_nxt; // R12
  end

  assign RD_DATA = rd_r;
  assign COND = cond_r;
  assign IL_ACTIVE = il_r;
  assign FLAGS = flags_r;
  assign DONE = done_r;

  // Helper copies of the last instruction and its inputs for checking.
  logic h_v_r;
  logic [6:0] h_code_r;
  logic [7:0] h_addr_r;
  logic h_cond_r, h_il_r, h_prev_r, h_stk_r, h_old_r;
  logic [`LBCE_FLAG_BITS-1:0] h_flags_r;
  logic [$clog2(`LBCE_EDGE_SLOTS)-1:0] h_slot_r;
  logic h_now;

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      h_v_r <= 1'b0;
      h_code_r <= '0;
      h_addr_r <= '0;
      h_cond_r <= 1'b0;
      h_il_r <= 1'b0;
      h_prev_r <= 1'b0;
      h_stk_r <= 1'b0;
      h_old_r <= 1'b0;
      h_flags_r <= '0;
      h_slot_r <= '0;
    end
    else
    begin
      h_v_r <= INSTR_VALID;
      h_code_r <= INSTR.code;
      h_addr_r <= INSTR.addr;
      h_cond_r <= cond_r;
      h_il_r <= il_r;
      h_prev_r <= prev_c;
      h_stk_r <= stk_r[0];
      h_old_r <= opnd;
      h_flags_r <= flags_r;
      h_slot_r <= INSTR.slot;
    end
  end

  assign h_now = rd_bit(h_addr_r, bits_r, ret_r);

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  sequence s_out_done;
    h_v_r && h_code_r == `LBCE_OP_OUT;
  endsequence

  // A live latch step whose set input alone was on.
  sequence s_latch_set;
    h_v_r && h_code_r == `LBCE_OP_LATCH && !h_il_r && !h_cond_r && h_stk_r;
  endsequence

  a_blk_and: assert property ((h_v_r && h_code_r == `LBCE_OP_AND_BLK) // R1
    |-> cond_r == (h_cond_r & h_stk_r))
    else $error("and block combine result wrong");
  a_blk_or: assert property ((h_v_r && h_code_r == `LBCE_OP_OR_BLK) // R1
    |-> cond_r == (h_cond_r | h_stk_r))
    else $error("or block combine result wrong");
  a_out_bit: assert property (s_out_done // R2
    |-> h_now == (h_cond_r & ~h_il_r))
    else $error("output bit does not follow condition");
  a_outn_bit: assert property ((h_v_r && h_code_r == `LBCE_OP_OUT_NOT) // R3
    |-> h_now == (~h_cond_r & ~h_il_r))
    else $error("inverted output bit wrong");
  a_rise_pulse: assert property ((h_v_r && h_code_r == `LBCE_OP_RISE // R5
    && !h_il_r) |-> h_now == (~h_prev_r & h_cond_r))
    else $error("rising pulse wrong");
  a_fall_pulse: assert property ((h_v_r && h_code_r == `LBCE_OP_FALL // R7
    && !h_il_r) |-> h_now == (h_prev_r & ~h_cond_r))
    else $error("falling pulse wrong");
  a_edge_store: assert property ((h_v_r && !h_il_r // R4
    && (h_code_r == `LBCE_OP_RISE || h_code_r == `LBCE_OP_FALL))
    |-> prev_r[h_slot_r] == h_cond_r)
    else $error("edge memory not updated");
  a_latch_set: assert property (s_latch_set |-> h_now) // R9
    else $error("latch set did not take");
  a_latch_reset: assert property ((h_v_r && h_code_r == `LBCE_OP_LATCH // R16
    && !h_il_r && h_cond_r) |-> !h_now)
    else $error("latch reset did not win");
  a_latch_hold: assert property ((h_v_r && h_code_r == `LBCE_OP_LATCH // R11
    && (h_il_r || (!h_cond_r && !h_stk_r))) |-> h_now == h_old_r)
    else $error("latch bit not held");
  a_latch_flags: assert property ((h_v_r && h_code_r == `LBCE_OP_LATCH) // R13
    |-> flags_r == h_flags_r)
    else $error("latch changed the flags");
  a_edge_frozen: assert property ((INSTR_VALID && il_r // R15
    && (INSTR.code == `LBCE_OP_RISE || INSTR.code == `LBCE_OP_FALL))
    |=> $stable(prev_r))
    else $error("edge memory updated under interlock");
  a_done_pulse: assert property (INSTR_VALID |=> DONE) // R17
    else $error("instruction not acknowledged");

endmodule // lbce_executor

// [test_ladder_bit_control_executor.sv]
`include "lbce_regs.svh"

module test_ladder_bit_control_executor
  import lbce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic valid = 1'b0;
  lbce_instr_t instr = '0;
  logic [7:0] rd_addr = 8'h00;
  logic rd_data, cond, il_active, done;
  logic [3:0] flags;
  int failures = 0;
  int tests_run = 0;
  integer seed = 32'hea7e;
  logic c, p, a, b, k;

  lbce_executor dut (.CLOCK(clock), .RSTN(rstn), .INSTR_VALID(valid),
    .INSTR(instr), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .COND(cond),
    .IL_ACTIVE(il_active), .FLAGS(flags), .DONE(done));

  // Free running 250 MHz clock.
  always #2 clock = ~clock;

  // Expected block combine result.
  function automatic logic blk(logic x, logic y, logic sel);
    return sel ? (x | y) : (x & y);
  endfunction

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Issue one instruction; it is taken at the following edge.
  task automatic op(input logic [6:0] cd, input logic [7:0] ad,
                    input logic [3:0] sl);
    @(posedge clock);
    valid <= 1'b1;
    instr <= '{cd, ad, sl};
  endtask

  // Address 0 is never written, so it serves as a constant zero.
  task automatic ld(input logic v);
    op(v ? `LBCE_OP_LOAD_NOT : `LBCE_OP_LOAD, 8'h00, 4'h0);
  endtask

  // Idle the port, then sample the bit a cycle later; DONE echoes the
  // valid level that the design saw at the idling edge.
  task automatic rd(input logic [7:0] ad, input logic exp);
    logic dv;
    @(posedge clock);
    dv = valid;
    valid <= 1'b0;
    rd_addr <= ad;
    #1 check(done, dv);
    @(posedge clock);
    #1 check(rd_data, exp);
  endtask

  // Hangs are cut well beyond the expected run length.
  initial
  begin
    #100000;
    failures++;
    finish_test();
  end

  initial
  begin
    logic [5:0] st, rt, et;
    st = 6'b11_0001;
    rt = 6'b01_0100;
    et = 6'b10_0011;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    #1 check({done, cond, il_active, rd_data}, 4'h0);
    check(flags, 4'h0);
    op(`LBCE_OP_SCAN_END, 8'h00, 4'h0);
    // Random block combines feeding direct and inverted outputs.
    repeat (20)
    begin
      a = 1'($random(seed));
      b = 1'($random(seed));
      k = 1'($random(seed));
      ld(a);
      op(`LBCE_OP_OUT, 8'h0A, 4'h0);
      ld(b);
      op(`LBCE_OP_OUT, 8'h0B, 4'h0);
      op(`LBCE_OP_LOAD, 8'h0A, 4'h0);
      op(`LBCE_OP_LOAD, 8'h0B, 4'h0);
      op(k ? `LBCE_OP_OR_BLK : `LBCE_OP_AND_BLK, 8'h00, 4'h0);
      op(`LBCE_OP_OUT, 8'h14, 4'h0);
      op(`LBCE_OP_OUT_NOT, 8'h15, 4'h0);
      // Bit-wise merges against the same two stored bits.
      op(`LBCE_OP_LOAD, 8'h0A, 4'h0);
      op(k ? `LBCE_OP_OR : `LBCE_OP_AND, 8'h0B, 4'h0);
      op(`LBCE_OP_OUT, 8'h16, 4'h0);
      op(`LBCE_OP_LOAD, 8'h0A, 4'h0);
      op(k ? `LBCE_OP_OR_NOT : `LBCE_OP_AND_NOT, 8'h0B, 4'h0);
      op(`LBCE_OP_OUT, 8'h17, 4'h0);
      rd(8'h14, blk(a, b, k));
      rd(8'h15, ~blk(a, b, k));
      rd(8'h16, blk(a, b, k));
      rd(8'h17, blk(a, ~b, k));
    end
    // Edge pulses; the first step is forced to a rising edge.
    p = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      c = (i == 0) ? 1'b1 : 1'($random(seed));
      ld(c);
      op(`LBCE_OP_RISE, 8'h1E, 4'h3);
      op(`LBCE_OP_FALL, 8'h1F, 4'h4);
      rd(8'h1E, ~p & c);
      rd(8'h1F, p & ~c);
      p = c;
    end
    // Latch table, bit 0 first: set, hold, reset, hold, both on, set again.
    op(`LBCE_OP_FLAGS_LD, 8'h05, 4'h0);
    for (int i = 0; i < 6; i++)
    begin
      ld(st[i]);
      ld(rt[i]);
      op(`LBCE_OP_LATCH, 8'h28, 4'h0);
      rd(8'h28, et[i]);
    end
    check(flags, 4'h5);
    // Interlocked section with its condition off.
    ld(1'b1);
    op(`LBCE_OP_RISE, 8'h2A, 4'h5);
    op(`LBCE_OP_OUT, 8'h29, 4'h0);
    op(`LBCE_OP_OUT, 8'h2B, 4'h0);
    rd(8'h29, 1'b1);
    rd(8'h2B, 1'b1);
    ld(1'b0);
    op(`LBCE_OP_IL_START, 8'h00, 4'h0);
    rd(8'h2A, 1'b1);
    check(il_active, 1'b1);
    ld(1'b0);
    ld(1'b1);
    op(`LBCE_OP_LATCH, 8'h28, 4'h0);
    rd(8'h28, 1'b1);
    ld(1'b1);
    op(`LBCE_OP_OUT, 8'h29, 4'h0);
    rd(8'h29, 1'b0);
    ld(1'b0);
    op(`LBCE_OP_OUT_NOT, 8'h2B, 4'h0);
    rd(8'h2B, 1'b0);
    ld(1'b0);
    op(`LBCE_OP_RISE, 8'h2A, 4'h5);
    op(`LBCE_OP_IL_CLEAR, 8'h00, 4'h0);
    ld(1'b1);
    op(`LBCE_OP_RISE, 8'h2A, 4'h5);
    rd(8'h2A, 1'b0);
    check(il_active, 1'b0);
    // A retentive latch survives a reset, a normal one does not.
    ld(1'b1);
    ld(1'b0);
    op(`LBCE_OP_LATCH, 8'hC5, 4'h0);
    rd(8'hC5, 1'b1);
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    ld(1'b0);
    rd(8'hC5, 1'b1);
    rd(8'h28, 1'b0);
    finish_test();
  end
endmodule // test_ladder_bit_control_executor
